// ### verilog/rtrs_pkg.sv
// Package with register map, field layout and timing constants of the timers.
`default_nettype none
package rtrs_pkg;
    // Per-timer base word indices; the APB byte address is four times that.
    localparam logic [7:0] TIMER0_BASE = 8'h60;
    localparam logic [7:0] TIMER1_BASE = 8'h65;
    localparam logic [7:0] TIMER2_BASE = 8'h6F;
    localparam logic [7:0] TIMER3_BASE = 8'h74;
    // Register positions relative to the control register.
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_IRQ_ENABLES = 8'h01;
    localparam logic [7:0] OFS_EVENT_FLAGS = 8'h02;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h03;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h04;
    // Special timer register groups; index offsets are relative to base.
    localparam logic [7:0] OFS_SPECIAL_FIRST = 8'h05;
    localparam int CAPTURE_REGS = 5;
    localparam int COMPARE_REGS = 10;
    localparam int PWM_REGS = 19;
    localparam int SPECIAL3_REGS = 19;
    // Debug break register (own choice), word index.
    localparam logic [7:0] DEBUG_BREAK_IDX = 8'hC0;
    // Control field positions.
    localparam int CTL_HALT = 7;
    localparam int CTL_SRC_HI = 6;
    localparam int CTL_SRC_LO = 5;
    localparam int CTL_DIV_HI = 4;
    localparam int CTL_DIV_LO = 3;
    localparam int CTL_REPEAT = 2;
    localparam int CTL_RELOAD = 1;
    localparam int CTL_ENABLE = 0;
    localparam int FLAG_EOC = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] IER_MASK = 8'h7F;
    localparam logic [15:0] RELOAD_RESET = 16'h0000;
    // Count sources.
    localparam logic [1:0] SRC_PRESCALE = 2'b00;
    localparam logic [1:0] SRC_RTC = 2'b01;
    localparam logic [1:0] SRC_FALL = 2'b10;
    localparam logic [1:0] SRC_RISE = 2'b11;
    localparam int PRESCALE_BITS = 8;
    // Bus request bundle.
    typedef struct packed {
        logic write;
        logic [7:0] index;
        logic [7:0] data;
    } rtrs_req_t;
endpackage
`default_nettype wire

// ### verilog/rtrs_timer.sv
// One 16-bit reload down-counter with its control, enable and flag registers.
`timescale 1ns/10ps
`default_nettype none
module rtrs_timer #(
    parameter int WIDTH = 16 // Counter width.
) (
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic ctlWrite, // Write strobe for the control register.
    input wire logic ierWrite, // Write strobe for the enable register.
    input wire logic rldLowWrite, // Write strobe for reload low byte.
    input wire logic rldHighWrite, // Write strobe for reload high byte.
    input wire logic flagRead, // Read strobe of the event flags.
    input wire logic [7:0] wdata, // Write data.
    input wire logic [rtrs_pkg::PRESCALE_BITS-1:0] prescale, // Prescaler.
    input wire logic rtcRise, // Real-time clock edge pulse.
    input wire logic evRise, // Event pin rising edge pulse.
    input wire logic evFall, // Event pin falling edge pulse.
    input wire logic debugBreak, // Debug break in progress.
    output logic [7:0] control, // Control register.
    output logic [7:0] irqEnables, // Interrupt enable register.
    output logic [7:0] eventFlags, // Event flag register.
    output logic [WIDTH-1:0] count, // Current count.
    output logic irq // Interrupt request, level.
);
    logic [WIDTH-1:0] reloadValue;
    logic [1:0] source;
    logic [1:0] divCode;
    logic tick;
    logic endOfCount;
    logic running;

    ////////////////////////////////////////////////////////////////////////
    // Select the count strobe; edges bypass the prescaler.
    assign source = control[rtrs_pkg::CTL_SRC_HI:rtrs_pkg::CTL_SRC_LO];
    assign divCode = control[rtrs_pkg::CTL_DIV_HI:rtrs_pkg::CTL_DIV_LO];
    always_comb begin
        unique case (source)
            rtrs_pkg::SRC_PRESCALE: begin
                unique case (divCode)
                    2'b00: tick = (prescale[1:0] == 2'b11);
                    2'b01: tick = (prescale[3:0] == 4'hF);
                    2'b10: tick = (prescale[5:0] == 6'h3F);
                    default: tick = (prescale == 8'hFF);
                endcase
            end
            rtrs_pkg::SRC_RTC: tick = rtcRise;
            rtrs_pkg::SRC_FALL: tick = evFall;
            default: tick = evRise;
        endcase
    end

    // Counting is paused during a break only when hold is requested.
    assign running = control[rtrs_pkg::CTL_ENABLE]
        && !(control[rtrs_pkg::CTL_HALT] && debugBreak);
    assign endOfCount = running && tick && (count == WIDTH'(1));

    ////////////////////////////////////////////////////////////////////////
    // Control register; single pass clears enable at end of count.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            control <= rtrs_pkg::CTL_RESET;
        end else if (ctlWrite) begin
            control <= wdata;
        end else if (endOfCount && !control[rtrs_pkg::CTL_REPEAT]) begin
            control[rtrs_pkg::CTL_ENABLE] <= 1'b0;
        end
    end

    // Interrupt enable register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqEnables <= rtrs_pkg::IER_RESET;
        end else if (ierWrite) begin
            irqEnables <= wdata & rtrs_pkg::IER_MASK;
        end
    end

    // Write-only reload value, byte at a time.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reloadValue <= WIDTH'(rtrs_pkg::RELOAD_RESET);
        end else begin
            if (rldLowWrite) begin
                reloadValue[7:0] <= wdata;
            end
            if (rldHighWrite) begin
                reloadValue[WIDTH-1:8] <= wdata[WIDTH-9:0];
            end
        end
    end

    // Down-counter with forced and automatic reload.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= '0;
        end else if (ctlWrite && wdata[rtrs_pkg::CTL_RELOAD]) begin
            count <= reloadValue;
        end else if (endOfCount) begin
            if (control[rtrs_pkg::CTL_REPEAT]) begin
                count <= reloadValue;
            end else begin
                count <= '0;
            end
        end else if (running && tick) begin
            count <= count - WIDTH'(1);
        end
    end

    // Event flags: set wins over the clear-on-read.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            eventFlags <= 8'h00;
        end else begin
            if (flagRead) begin
                eventFlags <= 8'h00;
            end
            if (endOfCount) begin
                eventFlags[rtrs_pkg::FLAG_EOC] <= 1'b1;
            end
        end
    end

    // Level request while an enabled flag stands.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(eventFlags & irqEnables);
        end
    end
endmodule
`default_nettype wire

// ### verilog/rtrs_top.sv
// APB register set holding four reload timers and special register groups.
//
// Function
// - Five byte registers per timer
// - Count read, reload written, same address
// - Count readable as high and low byte
// - Timer one adds capture control, two pairs
// - Timer three PWM shares capture/compare space
// - Capture and compare coexist, separate addresses
// - Two compare controls, four value pairs
// - Three PWM controls, rise/fall pairs
// - Halt bit holds count during break
// - Source field picks clock, RTC, edge
// - Prescale divides by 4/16/64/256
// - Single pass clears enable at end
// - Repeat mode reloads at end
// - Writing force reload loads counter
// - Enable bit starts and stops timer
// - Control registers at fixed addresses, zero reset
// - Edge sources bypass the prescaler
// - Reading event flags clears them
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`default_nettype none
module rtrs_top #(
    parameter int TIMERS = 4 // Number of timers.
) (
    input wire logic clock, // System clock, 20 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error on unmapped address.
    input wire logic rtcClock, // Real-time clock input.
    input wire logic [TIMERS-1:0] eventCountPin, // Event pins per timer.
    input wire logic debugBreakPin, // Debug break pin.
    output logic [TIMERS-1:0] irq // Interrupt per timer.
);
    localparam int NSPEC = rtrs_pkg::SPECIAL3_REGS;
    localparam int NCAP = rtrs_pkg::CAPTURE_REGS;
    localparam logic [7:0] BASES [4] = '{rtrs_pkg::TIMER0_BASE,
        rtrs_pkg::TIMER1_BASE, rtrs_pkg::TIMER2_BASE,
        rtrs_pkg::TIMER3_BASE};
    rtrs_pkg::rtrs_req_t req;
    logic access;
    logic [7:0] ctlQ [TIMERS];
    logic [7:0] ierQ [TIMERS];
    logic [7:0] iirQ [TIMERS];
    logic [15:0] cntQ [TIMERS];
    logic [TIMERS-1:0] irqQ;
    logic [TIMERS-1:0] ctlWr, ierWr, rlLoWr, rlHiWr, iirRd;
    logic [7:0] prescale;
    logic [2:0] rtcSync;
    logic [TIMERS-1:0] evMeta, evSync, evLast;
    logic breakMeta, breakSync;
    logic [1:0] debugBreakReg;
    // Timer-one capture group and timer-three shared group storage.
    logic [7:0] captureRegs [NCAP];
    logic [7:0] specialRegs [NSPEC];
    logic mapped;
    logic rtcRise;
    logic [TIMERS-1:0] evRise;
    logic [TIMERS-1:0] evFall;
    logic [7:0] next_rdata;
    logic next_err;
    logic [7:0] off;
    logic hit;

    ////////////////////////////////////////////////////////////////////////
    // Decode of the APB request into a word index.
    assign req = {pwrite, paddr[9:2], pwdata[7:0]};

    // Only the lowest kilobyte is decoded; a refused write must not land.
    assign mapped = (paddr[11:10] == 2'b00);
    assign access = psel && penable && pready && mapped;

    // One wait state: pready rises in the second access cycle.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !pready && penable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Synchronise pins and the free-running prescaler.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rtcSync <= 3'b000;
            evMeta <= '0;
            evSync <= '0;
            evLast <= '0;
            breakMeta <= 1'b0;
            breakSync <= 1'b0;
        end else begin
            rtcSync <= {rtcSync[1:0], rtcClock};
            evMeta <= eventCountPin;
            evSync <= evMeta;
            evLast <= evSync;
            breakMeta <= debugBreakPin;
            breakSync <= breakMeta;
        end
    end

    // Edge pulses from the second synchroniser stage and its delayed copy.
    assign rtcRise = rtcSync[1] && !rtcSync[2];
    assign evRise = evSync & ~evLast;
    assign evFall = ~evSync & evLast;

    // Prescaler counter shared by all timers.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prescale <= 8'h00;
        end else begin
            prescale <= prescale + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-timer strobes from the decoded index.
    always_comb begin
        ctlWr = '0;
        ierWr = '0;
        rlLoWr = '0;
        rlHiWr = '0;
        iirRd = '0;
        for (int t = 0; t < TIMERS; t++) begin
            if (access && req.index == BASES[t] + rtrs_pkg::OFS_CONTROL) begin
                ctlWr[t] = req.write;
            end
            if (access
                && req.index == BASES[t] + rtrs_pkg::OFS_IRQ_ENABLES) begin
                ierWr[t] = req.write;
            end
            if (access
                && req.index == BASES[t] + rtrs_pkg::OFS_EVENT_FLAGS) begin
                iirRd[t] = !req.write;
            end
            if (access
                && req.index == BASES[t] + rtrs_pkg::OFS_COUNT_LOW) begin
                rlLoWr[t] = req.write;
            end
            if (access
                && req.index == BASES[t] + rtrs_pkg::OFS_COUNT_HIGH) begin
                rlHiWr[t] = req.write;
            end
        end
    end

    // Four timers, each with its own five byte registers.
    for (genvar g = 0; g < TIMERS; g++) begin : gTimer
        rtrs_timer #(
            .WIDTH(16)
        ) uTimer (
            .clock(clock),
            .rst(rst),
            .ctlWrite(ctlWr[g]),
            .ierWrite(ierWr[g]),
            .rldLowWrite(rlLoWr[g]),
            .rldHighWrite(rlHiWr[g]),
            .flagRead(iirRd[g]),
            .wdata(req.data),
            .prescale(prescale),
            .rtcRise(rtcRise),
            .evRise(evRise[g]),
            .evFall(evFall[g]),
            .debugBreak(breakSync || debugBreakReg[0]),
            .control(ctlQ[g]),
            .irqEnables(ierQ[g]),
            .eventFlags(iirQ[g]),
            .count(cntQ[g]),
            .irq(irqQ[g])
        );
    end

    // Interrupt outputs registered once more after the timer flip-flops.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irq <= '0;
        end else begin
            irq <= irqQ;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software debug break register.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            debugBreakReg <= 2'b00;
        end else if (access && req.write
                     && req.index == rtrs_pkg::DEBUG_BREAK_IDX) begin
            debugBreakReg <= req.data[1:0];
        end
    end

    // Timer-one capture group storage: control plus two value pairs.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NCAP; i++) begin
                captureRegs[i] <= 8'h00;
            end
        end else if (access && req.write) begin
            for (int i = 0; i < NCAP; i++) begin
                if (req.index == BASES[1] + rtrs_pkg::OFS_SPECIAL_FIRST
                    + 8'(i)) begin
                    captureRegs[i] <= req.data;
                end
            end
        end
    end

    // Timer-three group: capture then compare in separate slots; PWM
    // overlays the same slots, so software uses one or the other.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NSPEC; i++) begin
                specialRegs[i] <= 8'h00;
            end
        end else if (access && req.write) begin
            for (int i = 0; i < NSPEC; i++) begin
                if (req.index == BASES[3] + rtrs_pkg::OFS_SPECIAL_FIRST
                    + 8'(i)) begin
                    specialRegs[i] <= req.data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read multiplexer with error on unmapped indices.
    always_comb begin
        next_rdata = 8'h00;
        next_err = 1'b1;
        off = 8'h00;
        hit = 1'b0;
        if (req.index == rtrs_pkg::DEBUG_BREAK_IDX) begin
            next_rdata = {6'b000000, debugBreakReg};
            next_err = 1'b0;
        end
        for (int t = 0; t < TIMERS; t++) begin
            off = req.index - BASES[t];
            hit = req.index >= BASES[t]
                && off <= rtrs_pkg::OFS_COUNT_HIGH;
            if (hit) begin
                next_err = 1'b0;
                unique case (off)
                    rtrs_pkg::OFS_CONTROL: next_rdata = ctlQ[t];
                    rtrs_pkg::OFS_IRQ_ENABLES: next_rdata = ierQ[t];
                    rtrs_pkg::OFS_EVENT_FLAGS: next_rdata = iirQ[t];
                    rtrs_pkg::OFS_COUNT_LOW: begin
                        next_rdata = cntQ[t][7:0];
                    end
                    default: next_rdata = cntQ[t][15:8];
                endcase
            end
        end
        for (int i = 0; i < NCAP; i++) begin
            if (req.index == BASES[1] + rtrs_pkg::OFS_SPECIAL_FIRST
                + 8'(i)) begin
                next_rdata = captureRegs[i];
                next_err = 1'b0;
            end
        end
        for (int i = 0; i < NSPEC; i++) begin
            if (req.index == BASES[3] + rtrs_pkg::OFS_SPECIAL_FIRST
                + 8'(i)) begin
                // Shared slots read back whatever mode wrote them last.
                next_rdata = specialRegs[i];
                next_err = 1'b0;
            end
        end
        if (!mapped) begin
            next_err = 1'b1;
            next_rdata = 8'h00;
        end
    end

    // Registered read data and error, valid with pready.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else if (psel && penable && !pready) begin
            prdata <= {24'h00_0000, next_rdata};
            pslverr <= next_err;
        end else begin
            pslverr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### sim/rtrs_top_assertions.sv
// Checker for bus timing and interrupt behaviour of the timer register set.
`timescale 1ns/10ps
`default_nettype none
module rtrs_top_checker #(
    parameter int TIMERS = 4 // Number of timers.
) (
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB direction.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] prdata, // APB read data.
    input wire logic pready, // APB ready.
    input wire logic pslverr, // APB error.
    input wire logic [TIMERS-1:0] irq // Interrupt per timer.
);
    // All checks run on the system clock and rest during reset.
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////
    // The answer comes in the second access cycle and lasts one cycle.
    chk_ready_wait: assert property (psel && penable && !$past(penable)
        |-> !pready ##1 pready) else $error("ready not in second cycle");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    chk_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside an access");
    // Read data only changes when a transfer completes.
    chk_rdata_hold: assert property (!pready |-> $stable(prdata))
        else $error("read data changed without a transfer");
    // Addresses outside the map are refused, the control word is not.
    chk_err_range: assert property (pready && paddr[11:10] != 2'b00
        |-> pslverr) else $error("out of range address accepted");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_ctl_no_err: assert property (pready && paddr == 12'h180
        |-> !pslverr) else $error("control register refused");
    // Reading the flags drops the interrupt, which is otherwise a level.
    chk_irq_read: assert property (pready && !pwrite && paddr == 12'h188
        |-> ##[1:4] !irq[0]) else $error("interrupt kept after flag read");
    chk_irq_level: assert property ($rose(irq[0]) |=> irq[0])
        else $error("interrupt is not a level");
    // Main scenarios reached.
    cover property (pslverr);
    cover property ($rose(irq[0]));
    cover property (pready && pwrite && paddr == 12'h180);
endmodule
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the reload timer register set.
`timescale 1ns/10ps
`default_nettype none
module tb;
    localparam logic [7:0] CTL = rtrs_pkg::TIMER0_BASE;
    localparam logic [7:0] IER = CTL + rtrs_pkg::OFS_IRQ_ENABLES;
    localparam logic [7:0] FLG = CTL + rtrs_pkg::OFS_EVENT_FLAGS;
    localparam logic [7:0] CLO = CTL + rtrs_pkg::OFS_COUNT_LOW;
    localparam logic [7:0] CHI = CTL + rtrs_pkg::OFS_COUNT_HIGH;
    localparam logic [7:0] BASES [4] = '{rtrs_pkg::TIMER0_BASE,
        rtrs_pkg::TIMER1_BASE, rtrs_pkg::TIMER2_BASE, rtrs_pkg::TIMER3_BASE};
    logic clock, rst, psel, penable, pwrite, pready, pslverr;
    logic rtcClock, debugBreakPin, lastErr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] eventCountPin, irq;
    logic [7:0] v, c1, d;
    int nFail, checks, n;

    // Device under test.
    rtrs_top #(.TIMERS(4)) i_rtrs_top (.clock(clock), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rtcClock(rtcClock),
        .eventCountPin(eventCountPin), .debugBreakPin(debugBreakPin),
        .irq(irq));

    // System clock of 50 ns.
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////
    // Compares a seen byte with the expected one.
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            nFail++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, nFail);
        if (nFail == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until ready is sampled high.
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [7:0] wd);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, wd};
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            nFail++;
            tally_and_finish();
        end
        v = prdata[7:0];
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask

    // Register write and read by word index.
    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, {2'b00, idx, 2'b00}, wd);
    endtask
    task automatic rd(input logic [7:0] idx);
        bus(1'b0, {2'b00, idx, 2'b00}, 8'h00);
    endtask

    // Count decrement of timer zero between two reads sampled w + 4 cycles apart.
    task automatic gap(input int w);
        rd(CLO);
        c1 = v;
        repeat (w) @(posedge clock);
        rd(CLO);
        d = c1 - v;
    endtask

    // Waits a bounded time for the first timer interrupt.
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq[0] !== 1'b1 && k < 400) begin
            @(posedge clock);
            k++;
        end
        if (k >= 400) begin
            nFail++;
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence of tests.
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, rtcClock, debugBreakPin} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        eventCountPin = 4'h0;
        nFail = 0;
        checks = 0;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int t = 0; t < 4; t++) begin
            rd(BASES[t]);
            check(v, rtrs_pkg::CTL_RESET);
            check({7'h00, lastErr}, 8'h00);
            wr(BASES[t], 8'hF8);
            rd(BASES[t]);
            check(v, 8'hF8);
            wr(BASES[t], 8'h00);
            rd(BASES[t] + 8'h02);
            check(v, 8'h00);
            wr(BASES[t] + 8'h01, 8'hFF);
            rd(BASES[t] + 8'h01);
            check(v, 8'hFF & rtrs_pkg::IER_MASK);
            wr(BASES[t] + 8'h01, 8'h00);
        end
        bus(1'b1, 12'h800, 8'h55);
        check({7'h00, lastErr}, 8'h01);
        for (int i = 0; i < 24; i++) begin
            wr(i < 5 ? 8'h6A + i[7:0] : 8'h74 + i[7:0], {1'b1, i[5:0], 1'b0});
        end
        for (int i = 0; i < 24; i++) begin
            rd(i < 5 ? 8'h6A + i[7:0] : 8'h74 + i[7:0]);
            check(v, {1'b1, i[5:0], 1'b0});
        end
        $display("test registers done");
        wr(CLO, 8'h03);
        wr(CHI, 8'h01);
        wr(CTL, 8'h02);
        rd(CLO);
        check(v, 8'h03);
        rd(CHI);
        check(v, 8'h01);
        wr(CHI, 8'h00);
        wr(CTL, 8'h03);
        n = 0;
        do begin
            rd(CLO);
            n++;
        end while (v !== 8'h00 && n < 40);
        check(v, 8'h00);
        rd(CTL);
        check(v, 8'h02);
        check({7'h00, irq[0]}, 8'h00);
        rd(FLG);
        check(v, 8'h01);
        rd(FLG);
        check(v, 8'h00);
        $display("test single pass done");
        wr(IER, 8'h01);
        wr(CTL, 8'h03);
        wait_irq();
        check({4'h0, irq}, 8'h01);
        rd(FLG);
        check(v, 8'h01);
        repeat (4) @(posedge clock);
        check({7'h00, irq[0]}, 8'h00);
        wr(CLO, 8'h02);
        wr(CTL, 8'h07);
        wait_irq();
        rd(CTL);
        check(v, 8'h07);
        wr(CTL, 8'h04);
        rd(FLG);
        check(v, 8'h01);
        rd(CLO);
        check({7'h00, v === 8'h01 || v === 8'h02}, 8'h01);
        $display("test interrupt and repeat done");
        wr(CLO, 8'hFF);
        wr(CHI, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            wr(CTL, {3'b000, k[1:0], 3'b011});
            gap((4 << (2 * k)) * 64 - 4);
            check({7'h00, d >= 63 && d <= 66}, 8'h01);
        end
        $display("test prescale done");
        debugBreakPin <= 1'b1;
        wr(CTL, 8'h83);
        gap(40);
        check(d, 8'h00);
        wr(CTL, 8'h01);
        gap(40);
        check({7'h00, d !== 8'h00}, 8'h01);
        debugBreakPin <= 1'b0;
        wr(rtrs_pkg::DEBUG_BREAK_IDX, 8'h01);
        rd(rtrs_pkg::DEBUG_BREAK_IDX);
        check(v, 8'h01);
        wr(CTL, 8'h83);
        gap(40);
        check(d, 8'h00);
        wr(rtrs_pkg::DEBUG_BREAK_IDX, 8'h00);
        wr(CTL, 8'h00);
        gap(40);
        check(d, 8'h00);
        $display("test halt and enable done");
        for (int s = 1; s < 4; s++) begin
            wr(CTL, {1'b0, s[1:0], 5'b00011});
            rd(CLO);
            c1 = v;
            for (int p = 0; p < 7; p++) begin
                if (s == 1) begin
                    rtcClock <= ~rtcClock;
                end else begin
                    eventCountPin[0] <= ~eventCountPin[0];
                end
                repeat (4) @(posedge clock);
            end
            repeat (8) @(posedge clock);
            rd(CLO);
            check(c1 - v, s == 2 ? 8'h03 : 8'h04);
            rtcClock <= 1'b0;
            eventCountPin <= 4'h0;
            repeat (8) @(posedge clock);
        end
        $display("test edge sources done");
        tally_and_finish();
    end
endmodule

// Attach the checker to the top of the design.
bind rtrs_top rtrs_top_checker #(.TIMERS(TIMERS)) i_rtrs_top_checker (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
`default_nettype wire
